// [include/period_timer_pkg.sv]
// Package for the period match timer: field layouts, reset values, select codes.
// Assumes a single system clock; the instruction-clock tick comes from a divide-by-four stage.
package period_timer_pkg;

  localparam int COUNT_W = 8;
  localparam int OUT_SEL_W = 4;
  localparam int IN_SEL_W = 2;
  localparam int CTRL_W = 7;

  // Reset values
  localparam logic [COUNT_W-1:0] COUNT_RESET = 8'h00;
  localparam logic [COUNT_W-1:0] PERIOD_RESET = 8'hFF;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;

  // Instruction clock is the oscillator clock divided by four
  localparam int INSTR_DIV = 4;
  localparam logic [1:0] INSTR_LAST = 2'h3;

  // Input divider select codes
  localparam logic [IN_SEL_W-1:0] IN_DIV_1 = 2'h0;
  localparam logic [IN_SEL_W-1:0] IN_DIV_4 = 2'h1;
  localparam logic [IN_SEL_W-1:0] IN_DIV_16 = 2'h2;
  localparam logic [IN_SEL_W-1:0] IN_DIV_64 = 2'h3;
  localparam logic [5:0] IN_LAST_1 = 6'h00;
  localparam logic [5:0] IN_LAST_4 = 6'h03;
  localparam logic [5:0] IN_LAST_16 = 6'h0F;
  localparam logic [5:0] IN_LAST_64 = 6'h3F;

  // Control register layout: bit 6:3 output select, bit 2 run, bit 1:0 input select
  typedef struct packed {
    logic [OUT_SEL_W-1:0] output_divider_select;
    logic timer_on;
    logic [IN_SEL_W-1:0] input_divider_select;
  } timer_control_t;

  // One software write to the timer's registers
  typedef struct packed {
    logic count_we;
    logic period_we;
    logic control_we;
    logic [COUNT_W-1:0] wdata;
  } reg_write_t;

endpackage

// [hdl/output_divider.sv]
// Output divider: counts period match pulses and emits one event per (select + 1) matches.
// Assumes match pulses and clears come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module output_divider #(
  parameter int SEL_W = 4
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Control
  input wire logic clear_in,
  input wire logic [SEL_W-1:0] select_in,
  input wire logic match_in,
  // Result
  output logic event_out
);

  logic [SEL_W-1:0] count_q;
  logic [SEL_W-1:0] count_d;
  logic done;
  logic event_d;

  // Completion when the count has reached the selected ratio minus one
  assign done = match_in && (count_q >= select_in);
  assign count_d = clear_in ? '0 : (done ? '0 : (match_in ? count_q + 1'b1 : count_q));
  assign event_d = done && !clear_in;

  // Counter is cleared together with the input divider
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count_q <= '0;
      event_out <= 1'b0;
    end else begin
      count_q <= count_d;
      event_out <= event_d;
    end
  end

endmodule
`default_nettype wire

// [hdl/period_match_timer.sv]
// Period match timer: 8-bit up counter with input divider, period compare and output divider.
// Assumes software writes arrive as same-clock strobes; device resets arrive as pulses.
// Sleep freezes the phase counter too, so counting resumes where it stopped on wake-up.
// The match pulse and flag are registered; nothing reaches an output combinationally.
//
// What this block does
// RULE1: Count clock is the instruction tick, one per four system clocks.
// RULE2: Input divider offers pass-through, divide by four, divide by sixteen and divide by sixty-four.
// RULE3: Count starts at zero and increments on each divided tick except the tick that matches.
// RULE4: Count compared with period on each divided tick; equality there gives the match pulse.
// RULE5: Match pulse zeroes the count next cycle and clocks the output divider.
// RULE6: Software reads and writes count and period directly.
// RULE7: Any device reset zeroes count and sets period to all ones.
// RULE8: Count write, control write and resets clear both divider counters.
// RULE9: Output divider completion sets a sticky match event flag.
// RULE10: Interrupt request raised only while flag and enable are both set.
// RULE11: Four-bit output select chooses ratios one-to-one through one-to-sixteen.
// RULE12: Match pulse is registered, no asynchronous path to the output.
// RULE13: During sleep nothing counts and count and period hold. Software writes to count and period still land during sleep.
// RULE14: Input select 00, 01, 10 divide by 1, 4, 16; 11 by 64.
// RULE15: Output select n gives one event per n plus one matches.
`timescale 1ns/10ps
`default_nettype none
module period_match_timer #(
  parameter int COUNT_W = period_timer_pkg::COUNT_W
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Device reset sources other than power-on, each a one-cycle pulse
  input wire logic brownout_reset_in,
  input wire logic external_reset_pin_in,
  input wire logic watchdog_reset_in,
  input wire logic stack_overflow_reset_in,
  input wire logic stack_underflow_reset_in,
  input wire logic reset_instruction_in,
  // Processor state
  input wire logic sleep_in,
  // Software register writes
  input wire period_timer_pkg::reg_write_t reg_write_in,
  input wire period_timer_pkg::timer_control_t control_write_in,
  // Flag and enable bits
  input wire logic match_event_flag_clear_in,
  input wire logic match_event_enable_in,
  // Register read back
  output logic [COUNT_W-1:0] timer_count_out,
  output logic [COUNT_W-1:0] period_value_out,
  output period_timer_pkg::timer_control_t timer_control_out,
  // Timer output and interrupt
  output logic period_match_pulse_out,
  output logic match_event_flag_out,
  output logic irq_out
);

  logic [COUNT_W-1:0] count_q;
  logic [COUNT_W-1:0] count_d;
  logic [COUNT_W-1:0] period_q;
  logic [COUNT_W-1:0] period_d;
  // Widths of the phase counter and the input divider follow their terminal counts
  localparam int PHASE_W = $bits(period_timer_pkg::INSTR_LAST);
  localparam int IN_DIV_W = $bits(period_timer_pkg::IN_LAST_64);

  period_timer_pkg::timer_control_t control_q;
  period_timer_pkg::timer_control_t control_d;
  logic [PHASE_W-1:0] instr_q;
  logic [PHASE_W-1:0] instr_d;
  logic [IN_DIV_W-1:0] in_div_q;
  logic [IN_DIV_W-1:0] in_div_d;
  logic [IN_DIV_W-1:0] in_last;
  logic div_wrap;
  logic [COUNT_W-1:0] count_step;
  logic match_q;
  logic flag_q;
  logic flag_d;
  logic irq_d;
  logic any_reset;
  logic div_clear;
  logic instr_tick;
  logic div_tick;
  logic match_now;
  logic out_event;

  // Reset sources that restore the timer like a power-on does
  assign any_reset = brownout_reset_in | external_reset_pin_in | watchdog_reset_in |
                     stack_overflow_reset_in | stack_underflow_reset_in | reset_instruction_in; // RULE7

  // Dividers restart on count or control writes and on any reset
  assign div_clear = any_reset | reg_write_in.count_we | reg_write_in.control_we; // RULE8

  // Instruction tick, one per four system clocks, none in sleep
  assign instr_tick = (instr_q == period_timer_pkg::INSTR_LAST) && !sleep_in; // RULE1 RULE13

  // Phase counter holds in sleep so the first tick after wake-up is not short
  assign instr_d = sleep_in ? instr_q : instr_q + 1'b1; // RULE13

  // Input divider terminal count per select code; the fourth code divides by 64
  function automatic logic [IN_DIV_W-1:0] in_last_of(input logic [period_timer_pkg::IN_SEL_W-1:0] sel);
    logic [IN_DIV_W-1:0] last;
    case (sel)
      period_timer_pkg::IN_DIV_1: last = period_timer_pkg::IN_LAST_1;
      period_timer_pkg::IN_DIV_4: last = period_timer_pkg::IN_LAST_4;
      period_timer_pkg::IN_DIV_16: last = period_timer_pkg::IN_LAST_16;
      period_timer_pkg::IN_DIV_64: last = period_timer_pkg::IN_LAST_64;
      default: last = period_timer_pkg::IN_LAST_64;
    endcase
    return last;
  endfunction

  // Input divider wraps at its terminal count and gives the divided tick there
  assign in_last = in_last_of(control_q.input_divider_select); // RULE2 RULE14
  assign div_wrap = in_div_q >= in_last;
  assign div_tick = instr_tick && control_q.timer_on && div_wrap && !div_clear;
  assign in_div_d = div_clear ? '0 :
                    (instr_tick && control_q.timer_on) ? (div_wrap ? '0 : in_div_q + 1'b1) :
                    in_div_q; // RULE8

  // Compare on divided ticks of a running timer only, so a stopped or held equal count does not re-fire
  assign match_now = (count_q == period_q) && div_tick; // RULE4

  // Increment on a divided tick, but not on the tick that matches
  assign count_step = (div_tick && !match_now) ? count_q + 1'b1 : count_q; // RULE3

  // Count: writes win, match zeroes, divided tick increments
  assign count_d = any_reset ? period_timer_pkg::COUNT_RESET :
                   reg_write_in.count_we ? reg_write_in.wdata : // RULE6
                   sleep_in ? count_q : // RULE13
                   match_q ? period_timer_pkg::COUNT_RESET : // RULE5
                   count_step;

  assign period_d = any_reset ? period_timer_pkg::PERIOD_RESET :
                    reg_write_in.period_we ? reg_write_in.wdata : period_q; // RULE6 RULE7

  // Control next value; a control write never touches the count itself
  assign control_d = any_reset ? period_timer_pkg::CTRL_RESET :
                     (reg_write_in.control_we ? control_write_in : control_q); // RULE8

  // Sticky flag: a new event wins over a clear in the same cycle
  assign flag_d = any_reset ? 1'b0 : (out_event | (flag_q & !match_event_flag_clear_in)); // RULE9
  assign irq_d = flag_d & match_event_enable_in; // RULE10

  // Output divider driven by the registered match pulse
  output_divider #(
    .SEL_W(period_timer_pkg::OUT_SEL_W)
  ) u_output_divider (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .clear_in(div_clear),
    .select_in(control_q.output_divider_select),
    .match_in(match_q),
    .event_out(out_event)
  ); // RULE5 RULE11 RULE15

  // Count and period registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count_q <= period_timer_pkg::COUNT_RESET;
      period_q <= period_timer_pkg::PERIOD_RESET; // RULE7
    end else begin
      count_q <= count_d;
      period_q <= period_d;
    end
  end

  // Control register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      control_q <= period_timer_pkg::CTRL_RESET;
    end else begin
      control_q <= control_d;
    end
  end

  // Phase counter, input divider and the registered match
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      instr_q <= '0;
      in_div_q <= '0;
      match_q <= 1'b0;
    end else begin
      instr_q <= instr_d;
      in_div_q <= in_div_d;
      match_q <= match_now && !div_clear; // RULE12
    end
  end

  // Sticky match event flag
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  // Interrupt request, registered so it lines up with the flag output
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= irq_d;
    end
  end

  // Register read-back straight from flip-flops, same timing as the registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      timer_count_out <= period_timer_pkg::COUNT_RESET;
      period_value_out <= period_timer_pkg::PERIOD_RESET;
      timer_control_out <= period_timer_pkg::CTRL_RESET;
    end else begin
      timer_count_out <= count_d;
      period_value_out <= period_d;
      timer_control_out <= control_d;
    end
  end

  // Match pulse and flag outputs
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      period_match_pulse_out <= 1'b0;
      match_event_flag_out <= 1'b0;
    end else begin
      period_match_pulse_out <= match_now && !div_clear; // RULE12
      match_event_flag_out <= flag_d;
    end
  end

endmodule
`default_nettype wire

// [verification/period_timer_properties.sv]
// Checker for the period match timer: timing relations seen at the top ports.
// Assumes the bind below and the single system clock of the block.
`timescale 1ns/10ps
`default_nettype none
module period_timer_properties #(
  parameter int COUNT_W = 8
) (
  // Clock, resets and sleep
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic brownout_reset_in,
  input wire logic external_reset_pin_in,
  input wire logic watchdog_reset_in,
  input wire logic stack_overflow_reset_in,
  input wire logic stack_underflow_reset_in,
  input wire logic reset_instruction_in,
  input wire logic sleep_in,
  // Writes and flag bits
  input wire period_timer_pkg::reg_write_t reg_write_in,
  input wire period_timer_pkg::timer_control_t control_write_in,
  input wire logic match_event_flag_clear_in,
  input wire logic match_event_enable_in,
  // Outputs
  input wire logic [COUNT_W-1:0] timer_count_out,
  input wire logic [COUNT_W-1:0] period_value_out,
  input wire period_timer_pkg::timer_control_t timer_control_out,
  input wire logic period_match_pulse_out,
  input wire logic match_event_flag_out,
  input wire logic irq_out
);
  // Any synchronous reset source, and a cycle without software writes
  wire logic sync_rst = brownout_reset_in | external_reset_pin_in | watchdog_reset_in |
    stack_overflow_reset_in | stack_underflow_reset_in | reset_instruction_in;
  wire logic no_wr = !(reg_write_in.count_we | reg_write_in.period_we | reg_write_in.control_we);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Four quiet sleeping cycles cover the output register lag
  sequence asleep_s;
    (sleep_in && !sync_rst && no_wr)[*4];
  endsequence
  sequence quiet_match_s;
    period_match_pulse_out && !sync_rst && no_wr && !sleep_in;
  endsequence
  reset_values_a: assert property (sync_rst |-> ##[1:2] (timer_count_out == '0 &&
    period_value_out == period_timer_pkg::PERIOD_RESET)) else $error("reset values wrong");
  count_write_a: assert property (reg_write_in.count_we && !sync_rst |=>
    timer_count_out == $past(reg_write_in.wdata)) else $error("count write lost");
  period_write_a: assert property (reg_write_in.period_we && !sync_rst |=>
    period_value_out == $past(reg_write_in.wdata)) else $error("period write lost");
  control_write_a: assert property (reg_write_in.control_we && !sync_rst |=>
    timer_control_out == $past(control_write_in)) else $error("control write lost");
  sleep_hold_a: assert property (asleep_s |-> $stable(timer_count_out) &&
    $stable(period_value_out)) else $error("count moved in sleep");
  match_cause_a: assert property (period_match_pulse_out |->
    $past(timer_count_out) == $past(period_value_out)) else $error("match without equality");
  match_zero_a: assert property (quiet_match_s |=> timer_count_out == '0)
    else $error("count not zeroed after match");
  pulse_single_a: assert property (period_match_pulse_out |=> !period_match_pulse_out)
    else $error("match pulse too long");
  flag_cause_a: assert property ($rose(match_event_flag_out) |-> $past(period_match_pulse_out, 2))
    else $error("flag set without match");
  flag_sticky_a: assert property (match_event_flag_out && !match_event_flag_clear_in && !sync_rst
    |=> match_event_flag_out) else $error("flag dropped");
  irq_gate_a: assert property (irq_out == (match_event_flag_out && $past(match_event_enable_in)))
    else $error("irq not flag and enable");
endmodule
bind period_match_timer period_timer_properties #(.COUNT_W(COUNT_W)) u_period_timer_properties (
  .clk_in, .rst_in, .brownout_reset_in, .external_reset_pin_in, .watchdog_reset_in,
  .stack_overflow_reset_in, .stack_underflow_reset_in, .reset_instruction_in, .sleep_in,
  .reg_write_in, .control_write_in, .match_event_flag_clear_in, .match_event_enable_in,
  .timer_count_out, .period_value_out, .timer_control_out, .period_match_pulse_out,
  .match_event_flag_out, .irq_out);
`default_nettype wire

// [verification/period_match_timer_tb.sv]
// Testbench for the period match timer: writes, match spacing, output divider, resets.
// Assumes the checker is bound separately; the bench drives every port itself.
`timescale 1ns/10ps
`default_nettype none
module period_match_timer_tb;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [5:0] sync_rst = 6'h00;
  logic sleep_in = 1'b0;
  logic clr_flag = 1'b0;
  logic enable = 1'b0;
  period_timer_pkg::reg_write_t wr_req = '0;
  period_timer_pkg::timer_control_t ctl = '0;
  period_timer_pkg::timer_control_t ctl_seen;
  logic [7:0] count_seen, period_seen;
  logic pulse, flag, irq;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int n, p;
  int outs[3] = '{0, 3, 15};
  // 250 MHz clock and a hang guard
  always #2 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      test_done();
    end
  end
  period_match_timer u_period_match_timer (.clk_in(clk_in), .rst_in(rst_in),
    .brownout_reset_in(sync_rst[0]), .external_reset_pin_in(sync_rst[1]), .watchdog_reset_in(sync_rst[2]),
    .stack_overflow_reset_in(sync_rst[3]), .stack_underflow_reset_in(sync_rst[4]),
    .reset_instruction_in(sync_rst[5]), .sleep_in(sleep_in), .reg_write_in(wr_req), .control_write_in(ctl),
    .match_event_flag_clear_in(clr_flag), .match_event_enable_in(enable), .timer_count_out(count_seen),
    .period_value_out(period_seen), .timer_control_out(ctl_seen), .period_match_pulse_out(pulse),
    .match_event_flag_out(flag), .irq_out(irq));
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One write cycle; the flag is cleared alongside so each test starts clean
  task automatic wr(input logic [2:0] we, input logic [7:0] d, input logic [6:0] c);
    @(posedge clk_in);
    wr_req <= {we, d};
    ctl <= c;
    clr_flag <= 1'b1;
    @(posedge clk_in);
    wr_req <= '0;
    clr_flag <= 1'b0;
    @(negedge clk_in);
  endtask
  // Cycles up to the next match pulse, bounded
  task automatic gap(output int k);
    k = 0;
    do begin
      @(negedge clk_in);
      k++;
    end while (pulse !== 1'b1 && k < 3000);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    @(negedge clk_in);
    chk("count reset", 16'(count_seen), 16'h0000);
    chk("period reset", 16'(period_seen), 16'h00FF);
    // Match spacing is four clocks times the input ratio times period plus one
    wr(3'b010, 8'h03, 7'h00);
    for (int s = 0; s < 4; s++) begin
      wr(3'b001, 8'h00, {4'h0, 1'b1, 2'(s)});
      gap(n);
      gap(n);
      chk("match spacing", 16'(n), 16'(16'h0010 << (2 * s)));
    end
    // Output divider ratios, with the interrupt enabled once
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_in);
      enable <= (i == 1);
      wr(3'b001, 8'h00, {outs[i][3:0], 1'b0, 2'h0});
      wr(3'b001, 8'h00, {outs[i][3:0], 1'b1, 2'h0});
      p = 0;
      n = 0;
      while (flag !== 1'b1 && n < 2000) begin
        @(negedge clk_in);
        n++;
        if (pulse === 1'b1) p++;
      end
      chk("matches per flag", 16'(p), 16'(outs[i] + 1));
      chk("irq", 16'(irq), 16'(i == 1));
    end
    // Writes land while asleep, and nothing counts there
    @(posedge clk_in);
    sleep_in <= 1'b1;
    wr(3'b110, 8'hA5, 7'h00);
    chk("count write", 16'(count_seen), 16'h00A5);
    chk("period write", 16'(period_seen), 16'h00A5);
    wr(3'b001, 8'h00, 7'h7D);
    chk("control write", 16'(ctl_seen), 16'h007D);
    repeat (40) @(negedge clk_in);
    chk("count kept", 16'(count_seen), 16'h00A5);
    @(posedge clk_in);
    sleep_in <= 1'b0;
    // Every synchronous reset source restores count and period
    for (int r = 0; r < 6; r++) begin
      wr(3'b110, 8'h5A, 7'h00);
      @(posedge clk_in);
      sync_rst <= 6'h01 << r;
      @(posedge clk_in);
      sync_rst <= 6'h00;
      repeat (2) @(negedge clk_in);
      chk("count after reset", 16'(count_seen), 16'h0000);
      chk("period after reset", 16'(period_seen), 16'h00FF);
    end
    test_done();
  end
endmodule
`default_nettype wire
